//--- paged_window_pkg.sv
package paged_window_pkg;
	// I/O decode uses the lower ten address lines only
	localparam int IO_ADDR_BITS = 10;
	localparam logic [9:0] PAGE_LOW_OFS = 10'h258;
	localparam logic [9:0] PAGE_HIGH_OFS = 10'h259;
	// Values after reset
	localparam logic [7:0] PAGE_LOW_RST = 8'h00;
	localparam logic [7:0] PAGE_HIGH_RST = 8'h00;
	// Field positions of the high register, write side
	localparam int HI_A22_BIT = 0;
	localparam int HI_A23_BIT = 1;
	localparam int HI_FLAG1_BIT = 3;
	localparam int HI_FLAG2_BIT = 4;
	localparam int HI_SEL_BIT = 6;
	localparam int HI_RUN_BIT = 7;
	// Bits that hold state; bits 2 and 5 have no function
	localparam logic [7:0] HI_WR_MASK = 8'hdb;
	// Field positions of the high register, read side
	localparam int RD_BUSY_BIT = 0;
	localparam int RD_LINK1_BIT = 1;
	localparam int RD_LINK2_BIT = 2;
	// Memory window in the upper memory area
	localparam int MEM_ADDR_BITS = 20;
	localparam int WIN_BITS = 14;
	localparam logic [19:0] WIN_BASE = 20'hdc000;
	// Page address A14..A23 and the SRAM part of it (128K / 16K = 8 pages)
	localparam int PAGE_BITS = 10;
	localparam int SRAM_PAGE_BITS = 3;
endpackage

//--- win_if.sv
`timescale 1ns/1ps
// Paging state handed from the register block to the window decoder
interface win_if;
	logic [9:0] page; // A23..A14 as software wrote them
	logic sram_sel; // 1 routes the window to the static RAM
	logic flash_run; // 0 keeps flash in reset and powered down
	modport ctrl (output page, output sram_sel, output flash_run);
	modport dec (input page, input sram_sel, input flash_run);
endinterface

//--- window_decode.sv
`timescale 1ns/1ps
// Window decoder: turns a host memory cycle into a paged flash or SRAM cycle
module window_decode (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Host memory cycle
	input wire logic [19:0] mem_addr_i,
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	// Paging state
	win_if.dec win,
	// Memory side, all registered
	output logic [9:0] page_o,
	output logic [13:0] offset_o,
	output logic flash_ce_o,
	output logic sram_ce_o,
	output logic rd_o,
	output logic wr_o,
	output logic led_o
);
	typedef struct packed {
		logic [9:0] page;
		logic [13:0] offset;
		logic flash_ce;
		logic sram_ce;
		logic rd;
		logic wr;
		logic led;
	} dec_state_t;

	dec_state_t dec_q; // Registered memory-side view
	dec_state_t dec_d; // Next value
	logic hit; // Host cycle lands in the window

	// Window hit: top six address bits match, and a strobe is active
	assign hit = (mem_addr_i[19:14] == paged_window_pkg::WIN_BASE[19:14])
		&& (mem_rd_i || mem_wr_i);

	// Next-state logic
	always_comb
	begin
		dec_d = '0;
		dec_d.offset = mem_addr_i[13:0];
		dec_d.rd = hit && mem_rd_i;
		dec_d.wr = hit && mem_wr_i;
		if (win.sram_sel)
		begin
			// SRAM images every 128K; upper page bits are driven as zero
			dec_d.page = {7'h00, win.page[2:0]};
			dec_d.sram_ce = hit;
		end
		else
		begin
			// Full ten page bits reach all 16MB of flash
			dec_d.page = win.page;
			// A flash held in reset is never selected, which also guards writes
			dec_d.flash_ce = hit && win.flash_run;
		end
		// Indicator follows any flash cycle
		dec_d.led = dec_d.flash_ce;
	end

	// State register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dec_q <= '0;
		else
			dec_q <= dec_d;
	end

	assign page_o = dec_q.page;
	assign offset_o = dec_q.offset;
	assign flash_ce_o = dec_q.flash_ce;
	assign sram_ce_o = dec_q.sram_ce;
	assign rd_o = dec_q.rd;
	assign wr_o = dec_q.wr;
	assign led_o = dec_q.led;

	default clocking dcb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence flash_cycle_s;
		hit && !win.sram_sel && win.flash_run;
	endsequence

	chk_flash_select: assert property (flash_cycle_s |=> flash_ce_o && !sram_ce_o)
		else $error("flash window cycle not selected");
	chk_sram_only: assert property (sram_ce_o |-> $past(win.sram_sel) && !flash_ce_o)
		else $error("sram selected without select bit");
	chk_page_map: assert property (flash_cycle_s |=> page_o == $past(win.page))
		else $error("flash page address wrong");
	// Tied to the host cycle, not to the select, so a broken indicator path shows
	chk_led_flash: assert property (flash_cycle_s |=> led_o)
		else $error("activity indicator dark on flash access");
	chk_reset_guard: assert property (!win.flash_run |=> !flash_ce_o)
		else $error("flash selected while held in reset");
endmodule // window_decode

//--- paged_window_top.sv
`timescale 1ns/1ps
// Paged flash/SRAM window: two I/O paging registers plus the memory window decoder
module paged_window_top (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RST_I,
	// Host I/O cycle
	input wire logic [9:0] IO_ADDR_I,
	input wire logic IO_RD_I,
	input wire logic IO_WR_I,
	input wire logic [7:0] IO_DATA_I,
	output logic [7:0] IO_DATA_O,
	output logic IO_DATA_OE_O,
	// Host memory cycle
	input wire logic [19:0] MEM_ADDR_I,
	input wire logic MEM_RD_I,
	input wire logic MEM_WR_I,
	// Board status inputs
	input wire logic FLASH_BUSY_N_I,
	input wire logic USER_LINK_ONE_I,
	input wire logic USER_LINK_TWO_I,
	// Memory side
	output logic [9:0] PAGE_ADDR_O,
	output logic [13:0] WIN_OFFSET_O,
	output logic FLASH_CE_O,
	output logic SRAM_CE_O,
	output logic MEM_RD_O,
	output logic MEM_WR_O,
	output logic FLASH_RUN_O,
	output logic FLASH_LED_O
);
	// All register-side state in one word
	typedef struct packed {
		logic [7:0] page_low; // A21..A14
		logic [7:0] page_high; // Control register, masked bits only
		logic wr_prev; // Write strobe one cycle ago
		logic [7:0] rd_data; // Read data driven to the host
		logic rd_oe; // Host data bus enable
		logic flash_run; // Flash reset/powerdown pin, 1 = enabled
	} ctl_state_t;

	ctl_state_t ctl_q; // Current state
	ctl_state_t ctl_d; // Next state
	logic wr_edge; // First cycle of a write strobe
	logic low_hit; // Address selects the low register
	logic high_hit; // Address selects the high register
	logic [7:0] high_rd; // Composed read value of the high register

	win_if win(); // Paging state to the decoder

	// Address decode on the ten I/O lines that the bus really decodes
	assign low_hit = (IO_ADDR_I == paged_window_pkg::PAGE_LOW_OFS);
	assign high_hit = (IO_ADDR_I == paged_window_pkg::PAGE_HIGH_OFS);

	// A write is taken once per strobe so a long strobe cannot double-fire
	assign wr_edge = IO_WR_I && !ctl_q.wr_prev;

	// Read image: live status in bits 0-2, stored bits in 3,4,6, zero elsewhere
	always_comb
	begin
		high_rd = 8'h00;
		high_rd[paged_window_pkg::RD_BUSY_BIT] = FLASH_BUSY_N_I;
		high_rd[paged_window_pkg::RD_LINK1_BIT] = USER_LINK_ONE_I;
		high_rd[paged_window_pkg::RD_LINK2_BIT] = USER_LINK_TWO_I;
		high_rd[paged_window_pkg::HI_FLAG1_BIT] =
			ctl_q.page_high[paged_window_pkg::HI_FLAG1_BIT];
		high_rd[paged_window_pkg::HI_FLAG2_BIT] =
			ctl_q.page_high[paged_window_pkg::HI_FLAG2_BIT];
		high_rd[paged_window_pkg::HI_SEL_BIT] =
			ctl_q.page_high[paged_window_pkg::HI_SEL_BIT];
	end

	// Next-state logic for the register side
	always_comb
	begin
		ctl_d = ctl_q;
		ctl_d.wr_prev = IO_WR_I;
		// Low register is write only
		if (wr_edge && low_hit)
		begin
			ctl_d.page_low = IO_DATA_I;
		end
		// High register keeps only bits that have a function
		if (wr_edge && high_hit)
		begin
			ctl_d.page_high = IO_DATA_I & paged_window_pkg::HI_WR_MASK;
		end
		// Reset pin follows bit 7 from the same edge the register loads
		ctl_d.flash_run = ctl_d.page_high[paged_window_pkg::HI_RUN_BIT];
		// Only the high register answers reads; the low one stays off the bus
		ctl_d.rd_oe = IO_RD_I && high_hit;
		if (IO_RD_I && high_hit)
		begin
			ctl_d.rd_data = high_rd;
		end
		else
		begin
			ctl_d.rd_data = 8'h00;
		end
	end

	// State register, cleared by the system reset
	always_ff @(posedge MCLK_I)
	begin
		if (RST_I)
		begin
			ctl_q <= '0;
			ctl_q.page_low <= paged_window_pkg::PAGE_LOW_RST;
			ctl_q.page_high <= paged_window_pkg::PAGE_HIGH_RST;
		end
		else
		begin
			ctl_q <= ctl_d;
		end
	end

	// Paging state toward the decoder
	assign win.page = {ctl_q.page_high[paged_window_pkg::HI_A23_BIT],
		ctl_q.page_high[paged_window_pkg::HI_A22_BIT], ctl_q.page_low};
	assign win.sram_sel = ctl_q.page_high[paged_window_pkg::HI_SEL_BIT];
	assign win.flash_run = ctl_q.flash_run;

	// Register-side outputs
	assign IO_DATA_O = ctl_q.rd_data;
	assign IO_DATA_OE_O = ctl_q.rd_oe;
	assign FLASH_RUN_O = ctl_q.flash_run;

	// Memory window decoder; the new page applies from the cycle after the write
	window_decode u_decode (
		.clk_i(MCLK_I),
		.rst_i(RST_I),
		.mem_addr_i(MEM_ADDR_I),
		.mem_rd_i(MEM_RD_I),
		.mem_wr_i(MEM_WR_I),
		.win(win.dec),
		.page_o(PAGE_ADDR_O),
		.offset_o(WIN_OFFSET_O),
		.flash_ce_o(FLASH_CE_O),
		.sram_ce_o(SRAM_CE_O),
		.rd_o(MEM_RD_O),
		.wr_o(MEM_WR_O),
		.led_o(FLASH_LED_O)
	);

	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (RST_I);

	sequence low_write_s;
		wr_edge && low_hit;
	endsequence

	sequence high_write_s;
		wr_edge && high_hit;
	endsequence

	sequence high_read_s;
		IO_RD_I && high_hit;
	endsequence

	chk_reset_clear: assert property ($fell(RST_I) |->
		win.page == 10'h000 && !win.sram_sel && !FLASH_RUN_O)
		else $error("paging registers not cleared by reset");
	chk_low_write: assert property (low_write_s |=>
		win.page[7:0] == $past(IO_DATA_I))
		else $error("low page register write lost");
	chk_high_page: assert property (high_write_s |=>
		win.page[9:8] == $past(IO_DATA_I[1:0]))
		else $error("A22/A23 not taken from high register");
	chk_run_pin: assert property (high_write_s |=>
		FLASH_RUN_O == $past(IO_DATA_I[7]))
		else $error("flash run pin does not follow bit 7");
	chk_read_busy: assert property (high_read_s |=>
		IO_DATA_OE_O && IO_DATA_O[0] == $past(FLASH_BUSY_N_I))
		else $error("busy line not returned on bit 0");
	chk_read_links: assert property (high_read_s |=>
		IO_DATA_O[2:1] == $past({USER_LINK_TWO_I, USER_LINK_ONE_I}))
		else $error("user link states not returned");
	// Write at t0, read at t1, answer at t2: the written data lie two edges back
	chk_select_back: assert property (high_write_s ##1 high_read_s |=>
		IO_DATA_O[6] == $past(IO_DATA_I[6], 2))
		else $error("select bit does not read back");
	chk_flag_back: assert property (high_write_s ##1 high_read_s |=>
		IO_DATA_O[4:3] == $past(IO_DATA_I[4:3], 2))
		else $error("software flags do not read back");
	chk_dead_bits: assert property (high_read_s |=>
		IO_DATA_O[7] == 1'b0 && IO_DATA_O[5] == 1'b0)
		else $error("no-function bits read nonzero");
	chk_low_silent: assert property (IO_RD_I && low_hit |=> !IO_DATA_OE_O)
		else $error("write-only register answered a read");
endmodule // paged_window_top

//--- flash_side_model.sv
`timescale 1ns/1ps
// Far-side flash: busy line goes low for a few clocks after each program cycle
module flash_side_model #(
	parameter int BUSY_CYC = 4 // Program time in clocks, kept short for the run
) (
	// Clock
	input wire logic clk_i,
	// Flash pins from the window
	input wire logic run_i,
	input wire logic ce_i,
	input wire logic wr_i,
	// Ready/busy back to the board
	output logic busy_n_o
);
	int cnt = 0; // Clocks left in the current program cycle
	// A write starts programming; powerdown aborts it, as a real part would
	always @(posedge clk_i)
	begin
		if (!run_i)
			cnt <= 0;
		else if (ce_i && wr_i)
			cnt <= BUSY_CYC;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	// Low while programming
	assign busy_n_o = (cnt == 0);
endmodule // flash_side_model

//--- paged_window_top_tb.sv
`timescale 1ns/1ps
// Bench for the paged window: registers, status read-back and window decode
module paged_flash_sram_window_tb;
	logic clk = 0, rst = 1, io_rd = 0, io_wr = 0, mem_rd = 0, mem_wr = 0;
	logic link1 = 0, link2 = 1; // Link one fitted, link two open
	logic [9:0] io_addr = 10'h000;
	logic [7:0] io_wdat = 8'h00;
	logic [19:0] mem_addr = 20'h00000;
	logic [7:0] io_rdat, d;
	logic io_oe, oe, busy_n, fce, sce, rd_o, wr_o, run, led;
	logic [9:0] page;
	logic [13:0] offs;
	int fails = 0, cmp_count = 0, cycles = 0;
	paged_window_top i_dut (.MCLK_I(clk), .RST_I(rst), .IO_ADDR_I(io_addr), .IO_RD_I(io_rd),
		.IO_WR_I(io_wr), .IO_DATA_I(io_wdat), .IO_DATA_O(io_rdat), .IO_DATA_OE_O(io_oe),
		.MEM_ADDR_I(mem_addr), .MEM_RD_I(mem_rd), .MEM_WR_I(mem_wr),
		.FLASH_BUSY_N_I(busy_n), .USER_LINK_ONE_I(link1), .USER_LINK_TWO_I(link2),
		.PAGE_ADDR_O(page), .WIN_OFFSET_O(offs), .FLASH_CE_O(fce), .SRAM_CE_O(sce),
		.MEM_RD_O(rd_o), .MEM_WR_O(wr_o), .FLASH_RUN_O(run), .FLASH_LED_O(led));
	flash_side_model i_flash (.clk_i(clk), .run_i(run), .ce_i(fce), .wr_i(wr_o),
		.busy_n_o(busy_n));
	// 25 MHz clock
	initial forever #20 clk = ~clk;
	// Hang guard: the whole sequence needs well under a few hundred clocks
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			fails++;
			final_report;
		end
	end
	task automatic final_report;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Wide enough for page and offset together
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One write strobe; dropped on the next edge so each strobe writes once
	task automatic io_w(input logic [9:0] a, input logic [7:0] v);
		@(posedge clk);
		io_addr <= a;
		io_wdat <= v;
		io_wr <= 1;
		@(posedge clk);
		io_wr <= 0;
		// Let the register edge settle before anyone looks at the outputs
		#1;
	endtask
	// One-cycle read; answer is registered on the edge that samples the strobe
	task automatic io_r(input logic [9:0] a);
		@(posedge clk);
		io_addr <= a;
		io_rd <= 1;
		@(posedge clk);
		io_rd <= 0;
		#1;
		d = io_rdat;
		oe = io_oe;
	endtask
	// One-cycle memory cycle; selects are looked at in the answering cycle
	task automatic mem(input logic [19:0] a, input logic w);
		@(posedge clk);
		mem_addr <= a;
		mem_rd <= !w;
		mem_wr <= w;
		@(posedge clk);
		mem_rd <= 0;
		mem_wr <= 0;
		#1;
	endtask
	// State after reset: flash held down, target flash, window refused
	task automatic t_reset;
		chk(run, 0);
		io_r(10'h259);
		chk({oe, d}, {1'b1, 8'h05});
		mem(20'hdc000, 0);
		chk({fce, sce, led}, 0);
	endtask
	// SRAM target with flags; no-function bits dropped, read bit 7 zero
	task automatic t_sram;
		io_w(10'h258, 8'ha5);
		io_w(10'h259, 8'hff);
		chk(run, 1);
		io_r(10'h259);
		chk({oe, d}, {1'b1, 8'h5d});
		mem(20'hdc123, 1);
		chk({fce, sce, wr_o, led}, 4'b0110);
		chk({page, offs}, {10'h005, 14'h0123});
	endtask
	// Flash target at the window's top address and just outside both window ends
	task automatic t_flash;
		io_w(10'h259, 8'h83);
		mem(20'hdffff, 0);
		chk({fce, sce, rd_o, led}, 4'b1011);
		chk({page, offs}, {10'h3a5, 14'h3fff});
		mem(20'hdbfff, 0);
		chk({fce, sce, led}, 0);
		mem(20'he0000, 0);
		chk({fce, sce, led}, 0);
		io_r(10'h258);
		chk(oe, 0);
	endtask
	// Busy and link states seen through the read port, then powerdown
	task automatic t_status;
		@(posedge clk);
		link1 <= 1;
		link2 <= 0;
		mem(20'hdc000, 1);
		io_r(10'h259);
		chk(d, 8'h02);
		repeat (6) @(posedge clk);
		io_r(10'h259);
		chk(d, 8'h03);
		io_w(10'h259, 8'h03);
		@(posedge clk);
		#1;
		chk(run, 0);
		mem(20'hdc000, 0);
		chk({fce, led}, 0);
	endtask
	// Reset in mid-run clears a loaded page, select and run bit
	task automatic t_midreset;
		io_w(10'h258, 8'h5a);
		io_w(10'h259, 8'hd8);
		@(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		#1;
		chk({run, page, fce, sce, led}, 0);
		io_r(10'h259);
		chk({oe, d}, {1'b1, 8'h03});
		mem(20'hdc000, 0);
		chk({page, fce, sce}, 0);
	endtask
	// Main sequence
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 0;
		t_reset;
		t_sram;
		t_flash;
		t_status;
		t_midreset;
		final_report;
	end
endmodule // paged_flash_sram_window_tb
